/* File: hdl/return_and_noop_instr_exec.sv */
/*
  Execution of the no-operation, return, return-from-interrupt and return-with-literal
  instructions. Takes one decoded instruction word per cycle while ready is high.
  Assumes the core stalls fetch while ready is low and supplies the stack top value.
*/
// What this block does
// - Return from interrupt pops stack into program counter, two cycles.
// - Return from interrupt sets global_irq_enable, bit 7 of irq_control_reg.
// - Return with literal writes its 8-bit immediate into the accumulator.
// - Return with literal pops stack to program counter, two cycles, flags untouched.
// - Plain return pops stack to program counter, two cycles, nothing else changes.
`timescale 1ns/10ps
module return_and_noop_instr_exec
  import ret_exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire instr_s instr_i,
  input wire logic [PC_W-1:0] stack_top_entry_i,
  output exec_out_s exec_o
);
  typedef struct packed {
    logic [1:0] rst_sync;
    exec_state_e state;
    exec_out_s out;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic rst_n;
  logic [INSTR_W-1:0] w;
  logic is_lit;

  assign rst_n = cur.rst_sync[1];
  assign w = instr_i.word;
  assign is_lit = (w[INSTR_W-1:PREFIX_LSB] == RETURN_WITH_LITERAL_PREFIX);

  always_comb begin
    next_cur = cur;
    next_cur.rst_sync = {cur.rst_sync[0], 1'b1};
    next_cur.out.pop = 1'b0;
    next_cur.out.acc_we = 1'b0;
    next_cur.out.flush = 1'b0;
    if (!rst_n) begin
      next_cur.state = EXEC_FETCH;
      next_cur.out = '0;
      next_cur.out.pc = PC_RESET;
      next_cur.out.acc_data = ACC_RESET;
      next_cur.out.irq_control_reg = IRQ_CONTROL_RESET;
    end else begin
      case (cur.state)
        EXEC_FETCH: begin
          next_cur.out.ready = 1'b1;
          if (instr_i.valid) begin
            if (w == RETURN_FROM_IRQ_CODE) begin
              next_cur.out.pc = stack_top_entry_i;
              next_cur.out.pop = 1'b1;
              next_cur.out.irq_control_reg[GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
              next_cur.out.ready = 1'b0;
              next_cur.out.flush = 1'b1;
              next_cur.state = EXEC_SECOND;
            end else if (is_lit) begin
              next_cur.out.acc_data = w[DATA_W-1:0];
              next_cur.out.acc_we = 1'b1;
              next_cur.out.pc = stack_top_entry_i;
              next_cur.out.pop = 1'b1;
              next_cur.out.ready = 1'b0;
              next_cur.out.flush = 1'b1;
              next_cur.state = EXEC_SECOND;
            end else if (w == RETURN_CODE) begin
              next_cur.out.pc = stack_top_entry_i;
              next_cur.out.pop = 1'b1;
              next_cur.out.ready = 1'b0;
              next_cur.out.flush = 1'b1;
              next_cur.state = EXEC_SECOND;
            end else begin
              // Other words, no-operation among them, just advance the counter.
              next_cur.out.pc = PC_W'(cur.out.pc + 1'b1);
            end
          end
        end
        EXEC_SECOND: begin
          // The second cycle only lets the refetch at the returned address settle.
          next_cur.out.ready = 1'b1;
          next_cur.state = EXEC_FETCH;
        end
        default: begin
          next_cur.state = EXEC_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign exec_o = cur.out;
endmodule

/* File: hdl/ret_exec_pkg.sv */
/*
  Package for the return and no-operation execution block: opcode encodings, widths,
  field positions and reset values.
  Assumes a 14-bit instruction word and a 13-bit program counter in the surrounding core.
*/
package ret_exec_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam logic [INSTR_W-1:0] NOP_CODE = 14'h0000;
  localparam logic [INSTR_W-1:0] RETURN_CODE = 14'h0008;
  localparam logic [INSTR_W-1:0] RETURN_FROM_IRQ_CODE = 14'h0009;
  localparam logic [5:0] RETURN_WITH_LITERAL_PREFIX = 6'h0D;
  localparam int PREFIX_LSB = 8;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam logic [DATA_W-1:0] IRQ_CONTROL_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

  typedef enum logic [1:0] {
    EXEC_FETCH,
    EXEC_SECOND
  } exec_state_e;

  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
  } instr_s;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic pop;
    logic acc_we;
    logic [DATA_W-1:0] acc_data;
    logic [DATA_W-1:0] irq_control_reg;
    logic ready;
    logic flush;
  } exec_out_s;
endpackage

/* File: verification/ret_exec_monitor.sv */
/* Checker for the return and no-op block. Sees only its top ports. */
`timescale 1ns/10ps
module ret_exec_monitor
  import ret_exec_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire instr_s instr_i,
  input wire logic [PC_W-1:0] stack_top_entry_i,
  input wire exec_out_s exec_o
);
  wire tk = exec_o.ready & instr_i.valid;
  wire [INSTR_W-1:0] w = instr_i.word;
  wire [PC_W-1:0] s = stack_top_entry_i;
  wire ie = exec_o.irq_control_reg[GLOBAL_IRQ_ENABLE_BIT];
  wire lit = tk && w[13:8] == RETURN_WITH_LITERAL_PREFIX;
  wire pop = exec_o.pop;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_irq_ret_pop:
    assert property (tk && w == RETURN_FROM_IRQ_CODE |=> (pop && !exec_o.ready &&
      exec_o.pc == $past(s)) ##1 (!pop && exec_o.ready)) else $error("irq return");
  a_irq_sets_en:
    assert property (tk && w == RETURN_FROM_IRQ_CODE |=> ie) else $error("enable bit");
  a_lit_acc:
    assert property (lit |=> exec_o.acc_we && exec_o.acc_data == $past(w[7:0])) else $error("acc");
  a_lit_pop:
    assert property (lit |=> pop && exec_o.pc == $past(s) && $stable(ie)) else $error("lit pc");
  a_ret_pop:
    assert property (tk && w == RETURN_CODE |=> pop && exec_o.pc == $past(s) && $stable(ie)
      && !exec_o.acc_we) else $error("return");
  a_nop_step:
    assert property (tk && w == NOP_CODE |=> !pop && exec_o.ready &&
      exec_o.pc == PC_W'($past(exec_o.pc) + 1)) else $error("nop");
  cover property (tk && w == RETURN_FROM_IRQ_CODE);
  cover property (lit);
  cover property (tk && w == RETURN_CODE);
endmodule
bind return_and_noop_instr_exec ret_exec_monitor ret_exec_monitor_i (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .instr_i(instr_i), .stack_top_entry_i(stack_top_entry_i), .exec_o(exec_o));

/* File: verification/tb.sv */
/* Testbench for the return and no-op block. Drives every port; checker is bound. */
`timescale 1ns/10ps
module tb;
  import ret_exec_pkg::*;
  logic clk_i = 0;
  logic arst_n_i = 0;
  instr_s instr_i = '0;
  logic [PC_W-1:0] stack_top_entry_i = '0;
  exec_out_s exec_o;
  int fails = 0;
  int check_count = 0;
  return_and_noop_instr_exec return_and_noop_instr_exec_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .instr_i(instr_i), .stack_top_entry_i(stack_top_entry_i), .exec_o(exec_o));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic c);
    check_count++;
    if (c !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask
  // Waits for ready, offers one word for exactly one cycle, samples settled outputs.
  task automatic issue(input logic [INSTR_W-1:0] wd, input logic [PC_W-1:0] st);
    int n;
    n = 0;
    while (exec_o.ready !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 20) begin
        fails++;
        finish_test();
      end
    end
    @(posedge clk_i);
    instr_i <= '{1'b1, wd};
    stack_top_entry_i <= st;
    @(posedge clk_i);
    instr_i <= '0;
    #1;
  endtask
  task automatic t_nop(input logic [PC_W-1:0] epc);
    issue(NOP_CODE, 13'h0AAA);
    chk(exec_o.pc === epc && exec_o.pop === 1'b0 && exec_o.ready === 1'b1);
    chk(exec_o.flush === 1'b0 && exec_o.acc_we === 1'b0);
  endtask
  task automatic t_irq_ret();
    issue(RETURN_FROM_IRQ_CODE, 13'h1ABC);
    chk(exec_o.pc === 13'h1ABC && exec_o.pop === 1'b1 && exec_o.ready === 1'b0);
    chk(exec_o.irq_control_reg === 8'h80 && exec_o.flush === 1'b1);
  endtask
  task automatic t_lit_ret(input logic [7:0] k);
    issue({RETURN_WITH_LITERAL_PREFIX, k}, 13'h0123);
    chk(exec_o.acc_we === 1'b1 && exec_o.acc_data === k);
    chk(exec_o.pc === 13'h0123 && exec_o.irq_control_reg === 8'h80);
  endtask
  task automatic t_ret();
    issue(RETURN_CODE, 13'h1FFF);
    chk(exec_o.pc === 13'h1FFF && exec_o.acc_we === 1'b0 && exec_o.acc_data === 8'h00);
    chk(exec_o.pop === 1'b1 && exec_o.flush === 1'b1 && exec_o.ready === 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_nop(13'h0001);
    t_irq_ret();
    t_lit_ret(8'hFF);
    t_lit_ret(8'h00);
    t_ret();
    t_nop(13'h0000);
    finish_test();
  end
endmodule
